// ===== rtl/spbp_pkg.sv
// constants, types and helper functions for the six pin bidirectional port
//
// Notes on behaviour
// - six port pins, each input or output except pin three
// - direction bit one floats the pin driver
// - direction bit zero drives the output latch
// - pin three input only, direction reads one
// - reads return pins, writes load the latch
// - every data or modify write merges sampled pins, then latches
// - reset select set makes pin three read zero
// - analog pins read zero whatever the voltage
// - enabled peripheral takes its pin from the port
// - reset select set enables pin three pull-up
// - pin five: port, timer clock, crystal, clock
package spbp_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int SPBP_PINS = 6; // implemented port pins
   localparam int SPBP_ADDR_W = 8; // bus address width
   localparam int SPBP_DATA_W = 32; // bus data width

   // ***************************************************************
   // register offsets (byte addresses)
   // ***************************************************************
   localparam logic [7:0] SPBP_PORT_PIN_DATA = 8'h00; // pin levels / output latch
   localparam logic [7:0] SPBP_PIN_DIRECTION = 8'h04; // direction bits
   localparam logic [7:0] SPBP_PIN_CONFIG = 8'h08; // analog, reset select, pin five function
   localparam logic [7:0] SPBP_LATCH_STATUS = 8'h0c; // latch and live drive enables
   localparam logic [7:0] SPBP_BIT_MODIFY = 8'h10; // masked read-modify-write

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int SPBP_CFG_ANALOG_LSB = 0; // four analog select bits
   localparam int SPBP_CFG_RESET_SEL = 4; // external reset pin select
   localparam int SPBP_CFG_P5FN_LSB = 5; // two bit pin five function
   localparam int SPBP_MOD_MASK_LSB = 8; // modify mask in second byte
   localparam int SPBP_STAT_DRIVE_LSB = 8; // drive enables in status

   // ***************************************************************
   // reset values and fixed masks
   // ***************************************************************
   localparam logic [5:0] SPBP_LATCH_RESET = 6'h00; // output latch after reset
   localparam logic [5:0] SPBP_DIR_RESET = 6'h3f; // all pins inputs
   localparam logic [3:0] SPBP_ANALOG_RESET = 4'hf; // analog channels selected
   localparam logic SPBP_RESET_SEL_RESET = 1'b0; // pin three as plain input
   localparam logic [5:0] SPBP_INPUT_ONLY_MASK = 6'h08; // input only pin
   localparam logic [5:0] SPBP_PIN_FIVE_MASK = 6'h20; // multifunction pin
   localparam logic [1:0] SPBP_RESP_OKAY = 2'h0; // bus response okay
   localparam logic [1:0] SPBP_RESP_SLVERR = 2'h2; // bus response slave error

   // pin five function codes
   typedef enum logic [1:0]
   {
      SPBP_FN_PORT = 2'b00, // general purpose pin
      SPBP_FN_TIMER = 2'b01, // timer one clock input
      SPBP_FN_CRYSTAL = 2'b10, // crystal connection
      SPBP_FN_CLOCK = 2'b11 // external clock input
   } spbp_pin5_fn_type;

   // ***************************************************************
   // helpers
   // ***************************************************************

   // map four analog select bits onto pins 0, 1, 2 and 4
   function automatic logic [5:0] spbp_analog_pins(input logic [3:0] ans);
      return {1'b0, ans[3], 1'b0, ans[2:0]};
   endfunction

   // value that a read of the port returns
   function automatic logic [5:0] spbp_port_read(input logic [5:0] pins, input logic [3:0] ans,
                                                 input logic reset_sel);
      return pins & ~spbp_analog_pins(ans) & ~(reset_sel ? SPBP_INPUT_ONLY_MASK : 6'h00);
   endfunction

   // merge modified bits into the sampled port value
   function automatic logic [5:0] spbp_merge(input logic [5:0] base, input logic [5:0] value,
                                             input logic [5:0] mask);
      return (base & ~mask) | (value & mask);
   endfunction

   // word aligned form of a bus address
   function automatic logic [7:0] spbp_word(input logic [7:0] addr);
      return {addr[7:2], 2'b00};
   endfunction

endpackage

// ===== rtl/spbp_sync.sv
// two flip-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
module spbp_sync
(
   input wire logic clock, // core clock
   input wire logic reset, // synchronous reset, active high
   input wire logic [5:0] async_in, // raw pin levels
   output logic [5:0] sync_out // pin levels in the clock domain
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed
   {
      logic [5:0] stage1; // first stage, read only by stage2
      logic [5:0] stage2; // settled stage
   } spbp_sync_type;

   spbp_sync_type st; // registered state
   spbp_sync_type next_st; // next state

   // shift the pins through both stages
   always_comb
   begin
      next_st = st;
      next_st.stage1 = async_in;
      next_st.stage2 = st.stage1;
   end

   // register the stages
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sync_out = st.stage2;

endmodule

// ===== rtl/spbp_pin_mux.sv
// pin driver selection: port latch, peripheral or pin five function
`timescale 1ns/1ps
module spbp_pin_mux
(
   input wire logic clock, // core clock
   input wire logic reset, // synchronous reset, active high
   input wire logic [5:0] output_latch, // port output latch
   input wire logic [5:0] pin_direction_bits, // 1 = input
   input wire logic [5:0] periph_claim, // peripheral owns pin
   input wire logic [5:0] periph_drive, // peripheral output value
   input wire logic [5:0] periph_drive_oe_n, // peripheral enable, low drives
   input wire logic [1:0] pin_five_multifunction, // pin five function code
   input wire logic external_reset_pin_select, // pin three serves reset
   input wire logic pin_five_level, // synchronised pin five level
   output logic [5:0] pin_out, // pin output values
   output logic [5:0] pin_oe_n, // pin enables, low drives
   output logic [5:0] pullup_enable, // weak pull-up enables
   output logic timer_one_clock_input, // pin five to timer one
   output logic crystal_connection_in, // pin five to crystal
   output logic external_clock_input // pin five to clock input
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed
   {
      logic [5:0] out; // driven values
      logic [5:0] oe_n; // drive enables
      logic [5:0] pull; // pull-ups
      logic tmr; // timer clock
      logic xtal; // crystal select
      logic clk; // clock input select
   } spbp_mux_type;

   spbp_mux_type st; // registered state
   spbp_mux_type next_st; // next state

   // choose the owner of each pin driver
   always_comb
   begin
      next_st = st;
      for (int i = 0; i < spbp_pkg::SPBP_PINS; i++)
      begin
         if (periph_claim[i])
         begin
            // peripheral has the pin
            next_st.out[i] = periph_drive[i];
            next_st.oe_n[i] = periph_drive_oe_n[i];
         end
         else
         begin
            // direction decides float or drive
            next_st.out[i] = output_latch[i];
            next_st.oe_n[i] = pin_direction_bits[i];
         end
      end
      // pin five away from port use never drives
      if (pin_five_multifunction != spbp_pkg::SPBP_FN_PORT)
      begin
         next_st.out = next_st.out & ~spbp_pkg::SPBP_PIN_FIVE_MASK;
         next_st.oe_n = next_st.oe_n | spbp_pkg::SPBP_PIN_FIVE_MASK;
      end
      // the input only pin has no driver at all
      next_st.out = next_st.out & ~spbp_pkg::SPBP_INPUT_ONLY_MASK;
      next_st.oe_n = next_st.oe_n | spbp_pkg::SPBP_INPUT_ONLY_MASK;
      // pull-up follows the reset select
      next_st.pull = external_reset_pin_select ? spbp_pkg::SPBP_INPUT_ONLY_MASK : 6'h00;
      // pin five routing
      next_st.tmr = (pin_five_multifunction == spbp_pkg::SPBP_FN_TIMER) && pin_five_level;
      next_st.xtal = (pin_five_multifunction == spbp_pkg::SPBP_FN_CRYSTAL);
      next_st.clk = (pin_five_multifunction == spbp_pkg::SPBP_FN_CLOCK);
   end

   // register the drivers; reset leaves every pin floating
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         st <= '{out: spbp_pkg::SPBP_LATCH_RESET, oe_n: spbp_pkg::SPBP_DIR_RESET,
                 pull: 6'h00, tmr: 1'b0, xtal: 1'b0, clk: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pin_out = st.out;
   assign pin_oe_n = st.oe_n;
   assign pullup_enable = st.pull;
   assign timer_one_clock_input = st.tmr;
   assign crystal_connection_in = st.xtal;
   assign external_clock_input = st.clk;

endmodule

// ===== rtl/spbp_port.sv
// six pin bidirectional port with an AXI4-Lite register slave
`timescale 1ns/1ps
module spbp_port
(
   input wire logic CLOCK, // core clock, 20 MHz
   input wire logic RESET, // synchronous reset, active high
   input wire logic [7:0] AWADDR, // write address
   input wire logic [2:0] AWPROT, // write protection, unused
   input wire logic AWVALID, // write address valid
   output logic AWREADY, // write address ready
   input wire logic [31:0] WDATA, // write data
   input wire logic [3:0] WSTRB, // write byte strobes
   input wire logic WVALID, // write data valid
   output logic WREADY, // write data ready
   output logic [1:0] BRESP, // write response
   output logic BVALID, // write response valid
   input wire logic BREADY, // write response ready
   input wire logic [7:0] ARADDR, // read address
   input wire logic [2:0] ARPROT, // read protection, unused
   input wire logic ARVALID, // read address valid
   output logic ARREADY, // read address ready
   output logic [31:0] RDATA, // read data
   output logic [1:0] RRESP, // read response
   output logic RVALID, // read data valid
   input wire logic RREADY, // read data ready
   input wire logic [5:0] PIN_IN, // pin levels from the pads
   output logic [5:0] PIN_OUT, // pin output values
   output logic [5:0] PIN_OE_N, // pin drive enables, low drives
   input wire logic [5:0] PERIPH_CLAIM, // peripheral owns the pin
   input wire logic [5:0] PERIPH_DRIVE, // peripheral output values
   input wire logic [5:0] PERIPH_DRIVE_OE_N, // peripheral enables, low drives
   output logic [5:0] PULLUP_ENABLE, // weak pull-up enables
   output logic TIMER_ONE_CLOCK_INPUT, // pin five level to timer one
   output logic CRYSTAL_CONNECTION_IN, // pin five given to crystal
   output logic EXTERNAL_CLOCK_INPUT // pin five given to clock input
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed
   {
      logic [5:0] latch; // output latch
      logic [5:0] dir; // direction bits
      logic [3:0] analog; // analog select bits
      logic reset_sel; // pin three serves external reset
      logic [1:0] p5fn; // pin five function
      logic have_aw; // write address held
      logic [7:0] waddr; // held write address
      logic have_w; // write data held
      logic [31:0] wdata; // held write data
      logic [3:0] wstrb; // held strobes
      logic bvalid; // write response pending
      logic [1:0] bresp; // write response code
      logic rvalid; // read data pending
      logic [7:0] raddr; // address of pending read
      logic [31:0] rdata; // read data
      logic [1:0] rresp; // read response code
   } spbp_port_type;

   spbp_port_type st; // registered state
   spbp_port_type next_st; // next state
   logic [5:0] pins; // synchronised pin levels
   logic [5:0] port_pin_bits; // value a read of the port returns
   logic [5:0] modify_mask; // bits a committed write replaces
   logic [5:0] modify_value; // values for those bits
   logic [7:0] wword; // aligned write address
   logic [7:0] rword; // aligned read address
   logic wr_commit; // address and data both held
   logic ar_take; // read address taken this cycle

   // ***************************************************************
   // pin sampling and drivers
   // ***************************************************************

   // pins pass two flip-flops before any read logic sees them
   spbp_sync u_sync
   (
      .clock(CLOCK),
      .reset(RESET),
      .async_in(PIN_IN),
      .sync_out(pins)
   );

   // drivers, pull-up and pin five routing
   spbp_pin_mux u_mux
   (
      .clock(CLOCK),
      .reset(RESET),
      .output_latch(st.latch),
      .pin_direction_bits(st.dir),
      .periph_claim(PERIPH_CLAIM),
      .periph_drive(PERIPH_DRIVE),
      .periph_drive_oe_n(PERIPH_DRIVE_OE_N),
      .pin_five_multifunction(st.p5fn),
      .external_reset_pin_select(st.reset_sel),
      .pin_five_level(pins[5]),
      .pin_out(PIN_OUT),
      .pin_oe_n(PIN_OE_N),
      .pullup_enable(PULLUP_ENABLE),
      .timer_one_clock_input(TIMER_ONE_CLOCK_INPUT),
      .crystal_connection_in(CRYSTAL_CONNECTION_IN),
      .external_clock_input(EXTERNAL_CLOCK_INPUT)
   );

   // ***************************************************************
   // read value and write merge
   // ***************************************************************

   // analog pins and the reset pin read zero
   assign port_pin_bits = spbp_pkg::spbp_port_read(pins, st.analog, st.reset_sel);

   assign wword = spbp_pkg::spbp_word(st.waddr);
   assign rword = spbp_pkg::spbp_word(ARADDR);
   assign wr_commit = st.have_aw && st.have_w && !st.bvalid;
   assign ar_take = ARVALID && !st.rvalid;

   // which bits a write to the data or modify register replaces
   always_comb
   begin
      modify_mask = 6'h00;
      modify_value = st.wdata[5:0];
      if (wword == spbp_pkg::SPBP_PORT_PIN_DATA)
      begin
         // whole byte replaces every bit
         modify_mask = {6{st.wstrb[0]}};
      end
      else if (wword == spbp_pkg::SPBP_BIT_MODIFY)
      begin
         // second byte names the bits to change
         modify_mask = st.wstrb[1] ? st.wdata[spbp_pkg::SPBP_MOD_MASK_LSB +: 6] : 6'h00;
      end
   end

   // ***************************************************************
   // register file and bus handshakes
   // ***************************************************************

   // next state of the registers and both bus channels
   always_comb
   begin
      next_st = st;
      // write address and data are taken in either order
      if (AWVALID && !st.have_aw)
      begin
         next_st.have_aw = 1'b1;
         next_st.waddr = AWADDR;
      end
      if (WVALID && !st.have_w)
      begin
         next_st.have_w = 1'b1;
         next_st.wdata = WDATA;
         next_st.wstrb = WSTRB;
      end
      // both halves held: perform the write and answer
      if (wr_commit)
      begin
         next_st.have_aw = 1'b0;
         next_st.have_w = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = spbp_pkg::SPBP_RESP_OKAY;
         if (wword == spbp_pkg::SPBP_PORT_PIN_DATA || wword == spbp_pkg::SPBP_BIT_MODIFY)
         begin
            // sample the port, merge, store in the latch
            next_st.latch = spbp_pkg::spbp_merge(port_pin_bits, modify_value, modify_mask);
         end
         else if (wword == spbp_pkg::SPBP_PIN_DIRECTION)
         begin
            // the input only pin keeps its direction at one
            if (st.wstrb[0])
            begin
               next_st.dir = st.wdata[5:0] | spbp_pkg::SPBP_INPUT_ONLY_MASK;
            end
         end
         else if (wword == spbp_pkg::SPBP_PIN_CONFIG)
         begin
            // analog select, reset select and pin five function
            if (st.wstrb[0])
            begin
               next_st.analog = st.wdata[spbp_pkg::SPBP_CFG_ANALOG_LSB +: 4];
               next_st.reset_sel = st.wdata[spbp_pkg::SPBP_CFG_RESET_SEL];
               next_st.p5fn = st.wdata[spbp_pkg::SPBP_CFG_P5FN_LSB +: 2];
            end
         end
         else if (wword == spbp_pkg::SPBP_LATCH_STATUS)
         begin
            // status is read only; the write is dropped
            next_st.bresp = spbp_pkg::SPBP_RESP_OKAY;
         end
         else
         begin
            // unmapped address
            next_st.bresp = spbp_pkg::SPBP_RESP_SLVERR;
         end
      end
      // write response handed over
      if (st.bvalid && BREADY)
      begin
         next_st.bvalid = 1'b0;
      end
      // read address taken only while no data is pending
      if (ar_take)
      begin
         next_st.rvalid = 1'b1;
         next_st.raddr = ARADDR;
         next_st.rresp = spbp_pkg::SPBP_RESP_OKAY;
         next_st.rdata = 32'h0000_0000;
         if (rword == spbp_pkg::SPBP_PORT_PIN_DATA)
         begin
            // pin levels; bits six and up read zero
            next_st.rdata[5:0] = port_pin_bits;
         end
         else if (rword == spbp_pkg::SPBP_PIN_DIRECTION)
         begin
            // direction with the input only pin shown as one
            next_st.rdata[5:0] = st.dir | spbp_pkg::SPBP_INPUT_ONLY_MASK;
         end
         else if (rword == spbp_pkg::SPBP_PIN_CONFIG)
         begin
            // configuration read back
            next_st.rdata[spbp_pkg::SPBP_CFG_ANALOG_LSB +: 4] = st.analog;
            next_st.rdata[spbp_pkg::SPBP_CFG_RESET_SEL] = st.reset_sel;
            next_st.rdata[spbp_pkg::SPBP_CFG_P5FN_LSB +: 2] = st.p5fn;
         end
         else if (rword == spbp_pkg::SPBP_LATCH_STATUS)
         begin
            // latch contents and pins actually driven
            next_st.rdata[5:0] = st.latch;
            next_st.rdata[spbp_pkg::SPBP_STAT_DRIVE_LSB +: 6] = ~PIN_OE_N;
         end
         else if (rword == spbp_pkg::SPBP_BIT_MODIFY)
         begin
            // write only register reads zero
            next_st.rdata = 32'h0000_0000;
         end
         else
         begin
            // unmapped address
            next_st.rresp = spbp_pkg::SPBP_RESP_SLVERR;
         end
      end
      else if (st.rvalid && RREADY)
      begin
         // read data handed over
         next_st.rvalid = 1'b0;
      end
   end

   // register all state
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         st <= '0;
         st.latch <= spbp_pkg::SPBP_LATCH_RESET;
         st.dir <= spbp_pkg::SPBP_DIR_RESET;
         st.analog <= spbp_pkg::SPBP_ANALOG_RESET;
         st.reset_sel <= spbp_pkg::SPBP_RESET_SEL_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // handshake and data outputs
   assign AWREADY = !st.have_aw;
   assign WREADY = !st.have_w;
   assign BVALID = st.bvalid;
   assign BRESP = st.bresp;
   assign ARREADY = !st.rvalid;
   assign RVALID = st.rvalid;
   assign RDATA = st.rdata;
   assign RRESP = st.rresp;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   // a write to the data register is committed
   sequence data_write_s;
      wr_commit && wword == spbp_pkg::SPBP_PORT_PIN_DATA && st.wstrb[0];
   endsequence

   // a masked modify is committed
   sequence modify_write_s;
      wr_commit && wword == spbp_pkg::SPBP_BIT_MODIFY && st.wstrb[1];
   endsequence

   // a data register read is taken
   sequence data_read_s;
      ar_take && rword == spbp_pkg::SPBP_PORT_PIN_DATA;
   endsequence

   latch_load_a: assert property (data_write_s |=> st.latch == $past(st.wdata[5:0]))
      else $error("data write did not load the latch");

   modify_merge_a: assert property (modify_write_s |=> st.latch == (($past(port_pin_bits)
      & ~$past(st.wdata[13:8])) | ($past(st.wdata[5:0]) & $past(st.wdata[13:8]))))
      else $error("modify did not merge sampled pins");

   dir_three_a: assert property (st.rvalid && spbp_pkg::spbp_word(st.raddr) == spbp_pkg::SPBP_PIN_DIRECTION
      |-> RDATA[3])
      else $error("input only direction bit read zero");

   upper_zero_a: assert property (data_read_s ##1 st.rvalid |-> RDATA[31:6] == 26'h0)
      else $error("unimplemented data bits not zero");

   analog_zero_a: assert property (data_read_s and st.analog[0] |=> !RDATA[0])
      else $error("analog pin read nonzero");

   reset_pin_zero_a: assert property (data_read_s and st.reset_sel |=> !RDATA[3])
      else $error("reset pin read nonzero");

   drive_latch_a: assert property (!st.dir[0] && !PERIPH_CLAIM[0]
      |=> !PIN_OE_N[0] && PIN_OUT[0] == $past(st.latch[0]))
      else $error("output pin not driving the latch");

   float_input_a: assert property (st.dir[1] && !PERIPH_CLAIM[1] |=> PIN_OE_N[1])
      else $error("input pin is driven");

   never_drive_a: assert property (PIN_OE_N[3] [*2])
      else $error("input only pin driven");

   periph_owns_a: assert property (PERIPH_CLAIM[2] |=> PIN_OE_N[2] == $past(PERIPH_DRIVE_OE_N[2])
      && PIN_OUT[2] == $past(PERIPH_DRIVE[2]))
      else $error("peripheral did not get its pin");

   pullup_sel_a: assert property (1'b1 |=> PULLUP_ENABLE
      == ($past(st.reset_sel) ? spbp_pkg::SPBP_INPUT_ONLY_MASK : 6'h00))
      else $error("pull-up does not follow reset select");

   pin_five_a: assert property (st.p5fn != spbp_pkg::SPBP_FN_PORT |=> PIN_OE_N[5]
      && CRYSTAL_CONNECTION_IN == ($past(st.p5fn) == spbp_pkg::SPBP_FN_CRYSTAL))
      else $error("pin five function not honoured");

endmodule

// ===== verif/spbp_board.sv
// board model that drives and pulls the six port pads
`timescale 1ns/1ps
module spbp_board
(
   input wire logic [5:0] pin_out, // port drive values
   input wire logic [5:0] pin_oe_n, // port enables, low drives
   input wire logic [5:0] pull_en, // weak pull-up enables
   input wire logic [5:0] ext, // board drive values
   input wire logic [5:0] ext_en, // board drives the pad
   output logic [5:0] pin_in // resolved pad levels
);
   // port driver wins, then board, then pull-up, else a floating pad shows the inverse
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext)
      | (pin_oe_n & ~ext_en & (pull_en | ~pin_out));
endmodule

// ===== verif/spbp_port_bench.sv
// self-checking bench for the six pin port
`timescale 1ns/1ps
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, s); end end
module spbp_port_bench;
   logic clock = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0; // bus drives
   logic [7:0] awaddr = 0, araddr = 0, sd = 8'h50; // addresses, random state
   logic [31:0] wdata = 0, rdata, rv; // bus data
   logic [5:0] ext = 0, ext_en = 6'h3f, claim = 0, pdrv = 0, pin_in, pout, poe_n, pull, lat = 0, dir = 6'h3f, m;
   logic awready, wready, bvalid, arready, rvalid, tmr, xtal, eclk, rs = 0; // design outputs and model reset select
   logic [1:0] bresp, rresp, r; // responses
   logic [3:0] an = 4'hf; // model analog select
   int n_mismatch = 0, checks = 0, k; // counters
   spbp_port dut (.CLOCK(clock), .RESET(reset), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PIN_IN(pin_in), .PIN_OUT(pout),
      .PIN_OE_N(poe_n), .PERIPH_CLAIM(claim), .PERIPH_DRIVE(pdrv), .PERIPH_DRIVE_OE_N(~pdrv),
      .PULLUP_ENABLE(pull), .TIMER_ONE_CLOCK_INPUT(tmr), .CRYSTAL_CONNECTION_IN(xtal), .EXTERNAL_CLOCK_INPUT(eclk));
   spbp_board board (.pin_out(pout), .pin_oe_n(poe_n), .pull_en(pull), .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
   // ***********************
   // clock, random and model
   // ***********************
   initial forever #25 clock = ~clock;
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // expected port read: driven pins give the latch, others the board, analog and reset pins zero
   function automatic logic [31:0] exp_rd();
      logic [5:0] d;
      d = dir | 6'h08;
      return {26'h0, ((~d & lat) | (d & ext)) & ~{1'b0, an[3], 1'b0, an[2:0]} & ~{2'b0, rs, 3'b0}};
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bus write: address and data offered together, response awaited
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 40 && !(bvalid && !awvalid && !wvalid); i++)
      begin
         @(posedge clock);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      bready <= 0; r = bresp;
      @(posedge clock);
      if (i == 40) begin n_mismatch++; close_out; end
   endtask
   // bus read
   task automatic rd(input logic [7:0] a);
      int i;
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 40 && !(rvalid && !arvalid); i++)
      begin
         @(posedge clock);
         if (arready) arvalid <= 0;
      end
      rready <= 0; rv = rdata; r = rresp;
      @(posedge clock);
      if (i == 40) begin n_mismatch++; close_out; end
   endtask
   task st; repeat (4) @(posedge clock); endtask
   // ***********************
   // scenarios
   // ***********************
   initial
   begin
      repeat (16) @(posedge clock);
      reset <= 0; @(posedge clock);
      rd(8'h04); `CK("dir", 32'h3f, rv)
      `CK("oe", 6'h3f, poe_n)
      wr(8'h08, 0); an = 0; sd = nx(sd); ext <= sd[5:0] | 6'h08;
      wr(8'h04, 0); dir = 0; rd(8'h04); `CK("dir3", 32'h08, rv)
      sd = nx(sd); wr(8'h00, {24'h0, sd}); lat = sd[5:0]; st;
      `CK("oe", 6'h08, poe_n)
      `CK("out", lat & 6'h37, pout & 6'h37)
      rd(8'h00); `CK("rd", exp_rd(), rv)
      sd = nx(sd); m = sd[5:0]; sd = nx(sd);
      wr(8'h10, {18'h0, m, 2'h0, sd[5:0]}); lat = (exp_rd() & ~m) | (sd[5:0] & m); st;
      rd(8'h0c); `CK("lat", {18'h0, 6'h37, 2'h0, lat}, rv)
      wr(8'h08, 32'h10); rs = 1; ext_en <= 6'h37; st;
      `CK("pull", 6'h08, pull)
      rd(8'h00); `CK("rs", exp_rd(), rv)
      wr(8'h04, 32'h3f); dir = 6'h3f; wr(8'h08, 32'h1f); an = 4'hf; st;
      rd(8'h00); `CK("ana", exp_rd(), rv)
      wr(8'h04, 0);
      for (k = 1; k < 4; k++)
      begin
         wr(8'h08, k << 5); st;
         `CK("fn", {k == 2, k == 3, k == 1 && ext[5], 1'b1}, {xtal, eclk, tmr, poe_n[5]})
      end
      wr(8'h08, 0); claim <= 6'h05; sd = nx(sd); pdrv <= sd[5:0]; st;
      `CK("per", {~pdrv[0], pdrv[0]}, {poe_n[0], pout[0]})
      wr(8'h20, 0); `CK("resp", 2'h2, r)
      rd(8'h20); `CK("rrsp", 2'h2, r)
      close_out;
   end
endmodule
